/* hdl/fabric_pkg.sv */
// How it works
// - the program path takes a 21-bit fetch address and returns a 16-bit word on its read bus.
// - program memory writes carry only the low sixteen bits of the 32-bit core write bus.
// - the primary path has a 24-bit address, byte/word/long sizes, and a 32-bit read bus.
// - the secondary path serves word reads only and returns them on its own 16-bit bus.
// - every byte access has the top address bit forced to zero.
// - the peripheral register bus runs on the core clock and adds no wait cycles.
// - peripheral writes take the low half of the primary write data and peripheral reads return on the primary bus.
// - the primary data RAM port is 32 bits wide and every other data port is 16 bits.
// - flash control goes through peripheral registers while flash data moves directly.
// - active-low signals are asserted low and active-high signals are asserted high.
// - up to three accesses may proceed in one cycle across program and both data paths.
package fabric_pkg;
  localparam int PAB_W = 21;
  localparam int XAB_W = 24;
  localparam int WORD_W = 16;
  localparam int LONG_W = 32;
  // primary region bounds, range-compared against the whole 24-bit address (word address)
  localparam logic [XAB_W-1:0] RAM_BASE = 24'h000000;
  localparam logic [XAB_W-1:0] RAM_LIMIT = 24'h001FFF;
  localparam logic [XAB_W-1:0] DFLASH_BASE = 24'h004000;
  localparam logic [XAB_W-1:0] DFLASH_LIMIT = 24'h004FFF;
  localparam logic [XAB_W-1:0] PERIPH_BASE = 24'h00F000;
  localparam logic [XAB_W-1:0] PERIPH_LIMIT = 24'h00FFFF;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } size_e;

  typedef enum logic [3:0] {
    TGT_NONE = 4'h1,
    TGT_RAM = 4'h2,
    TGT_DFLASH = 4'h4,
    TGT_PERIPH = 4'h8
  } target_e;

  typedef struct packed {
    logic rd;
    logic wr;
    size_e size;
    logic [XAB_W-1:0] addr;
    logic [LONG_W-1:0] wdata;
  } pri_req_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [XAB_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } port16_s;
endpackage

/* hdl/region_decode.sv */
`timescale 1ns/100ps
// primary address region decoder, one-hot target
module region_decode (
  input wire logic [fabric_pkg::XAB_W-1:0] addr,
  output fabric_pkg::target_e target
);
  wire logic in_ram;
  wire logic in_dfl;
  wire logic in_per;
  // range compares
  assign in_ram = addr <= fabric_pkg::RAM_LIMIT;
  assign in_dfl = addr >= fabric_pkg::DFLASH_BASE && addr <= fabric_pkg::DFLASH_LIMIT;
  assign in_per = addr >= fabric_pkg::PERIPH_BASE && addr <= fabric_pkg::PERIPH_LIMIT;
  // exactly one target or none
  assign target = in_ram ? fabric_pkg::TGT_RAM :
                  in_dfl ? fabric_pkg::TGT_DFLASH :
                  in_per ? fabric_pkg::TGT_PERIPH : fabric_pkg::TGT_NONE;
endmodule // region_decode

/* hdl/core_system_bus_fabric.sv */
`timescale 1ns/100ps
// system bus fabric: program path, primary and secondary data paths, peripheral bus
module core_system_bus_fabric (
  input wire logic ref_clk,
  input wire logic nrst,
  // program path from core
  input wire logic prog_rd,
  input wire logic prog_wr,
  input wire logic [fabric_pkg::PAB_W-1:0] prog_addr,
  input wire logic [fabric_pkg::LONG_W-1:0] core_wdata,
  output logic [fabric_pkg::WORD_W-1:0] prog_rdata,
  // primary data path from core
  input wire fabric_pkg::pri_req_s pri_req,
  output logic [fabric_pkg::LONG_W-1:0] primary_rdata,
  output logic pri_unmapped,
  // secondary path from core
  input wire logic sec_rd,
  input wire logic [fabric_pkg::XAB_W-1:0] secondary_data_address_bus,
  output logic [fabric_pkg::WORD_W-1:0] secondary_read_data_bus,
  // program memory side
  output logic pm_rd,
  output logic pm_wr,
  output logic [fabric_pkg::PAB_W-1:0] pm_addr,
  output logic [fabric_pkg::WORD_W-1:0] pm_wdata,
  input wire logic [fabric_pkg::WORD_W-1:0] pm_rdata,
  // primary data RAM, 32 bits
  output logic ram_rd,
  output logic ram_wr,
  output fabric_pkg::size_e ram_size,
  output logic [fabric_pkg::XAB_W-1:0] ram_addr,
  output logic [fabric_pkg::LONG_W-1:0] ram_wdata,
  input wire logic [fabric_pkg::LONG_W-1:0] ram_rdata,
  // secondary data RAM read port, 16 bits
  output logic ram2_rd,
  output logic [fabric_pkg::XAB_W-1:0] ram2_addr,
  input wire logic [fabric_pkg::WORD_W-1:0] ram2_rdata,
  // data flash array of the flash_module, 16 bits, direct data
  output fabric_pkg::port16_s dflash,
  input wire logic [fabric_pkg::WORD_W-1:0] dflash_rdata,
  // peripheral_register_bus, 16 bits, flash control registers live here
  output fabric_pkg::port16_s peripheral_register_bus,
  input wire logic [fabric_pkg::WORD_W-1:0] periph_rdata
);
  fabric_pkg::target_e tgt;
  fabric_pkg::target_e tgt_q;
  logic [fabric_pkg::XAB_W-1:0] pri_addr;
  logic pri_byte;
  logic pri_act;
  logic pri_rd_q;
  logic prog_rd_q;
  logic sec_rd_q;
  logic [fabric_pkg::LONG_W-1:0] pri_rdata_mux;

  // byte accesses are confined to the lower half of the space
  assign pri_byte = pri_req.size == fabric_pkg::SZ_BYTE;
  assign pri_addr = pri_byte ? {1'b0, pri_req.addr[fabric_pkg::XAB_W-2:0]}
                             : pri_req.addr;
  assign pri_act = pri_req.rd | pri_req.wr;

  region_decode u_dec (
    .addr(pri_addr),
    .target(tgt)
  );

  // read data return selected by the target latched with the request
  assign pri_rdata_mux =
    (tgt_q == fabric_pkg::TGT_RAM) ? ram_rdata :
    (tgt_q == fabric_pkg::TGT_DFLASH) ? {16'h0000, dflash_rdata} :
    (tgt_q == fabric_pkg::TGT_PERIPH) ? {16'h0000, periph_rdata} : 32'h00000000;

  // program path request stage
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pm_rd <= 1'b0;
      pm_wr <= 1'b0;
      pm_addr <= '0;
      pm_wdata <= 16'h0000;
    end else begin
      pm_rd <= prog_rd;
      pm_wr <= prog_wr;
      pm_addr <= prog_addr;
      pm_wdata <= core_wdata[fabric_pkg::WORD_W-1:0];
    end
  end

  // primary path request stage, one target selected
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ram_rd <= 1'b0;
      ram_wr <= 1'b0;
      ram_size <= fabric_pkg::SZ_WORD;
      ram_addr <= '0;
      ram_wdata <= 32'h00000000;
      dflash <= '0;
      peripheral_register_bus <= '0;
      pri_unmapped <= 1'b0;
    end else begin
      ram_rd <= pri_req.rd && tgt == fabric_pkg::TGT_RAM;
      ram_wr <= pri_req.wr && tgt == fabric_pkg::TGT_RAM;
      ram_size <= pri_req.size;
      ram_addr <= pri_addr;
      ram_wdata <= pri_req.wdata;
      dflash.rd <= pri_req.rd && tgt == fabric_pkg::TGT_DFLASH;
      dflash.wr <= pri_req.wr && tgt == fabric_pkg::TGT_DFLASH;
      dflash.addr <= pri_addr;
      dflash.wdata <= pri_req.wdata[fabric_pkg::WORD_W-1:0];
      peripheral_register_bus.rd <= pri_req.rd && tgt == fabric_pkg::TGT_PERIPH;
      peripheral_register_bus.wr <= pri_req.wr && tgt == fabric_pkg::TGT_PERIPH;
      peripheral_register_bus.addr <= pri_addr;
      peripheral_register_bus.wdata <= pri_req.wdata[fabric_pkg::WORD_W-1:0];
      pri_unmapped <= pri_act && tgt == fabric_pkg::TGT_NONE;
    end
  end

  // secondary word-read request stage
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ram2_rd <= 1'b0;
      ram2_addr <= '0;
    end else begin
      ram2_rd <= sec_rd;
      ram2_addr <= secondary_data_address_bus;
    end
  end

  // response tracking
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tgt_q <= fabric_pkg::TGT_NONE;
      pri_rd_q <= 1'b0;
      prog_rd_q <= 1'b0;
      sec_rd_q <= 1'b0;
    end else begin
      tgt_q <= pri_req.rd ? tgt : fabric_pkg::TGT_NONE;
      pri_rd_q <= pri_req.rd;
      prog_rd_q <= prog_rd;
      sec_rd_q <= sec_rd;
    end
  end

  // read return registers: memory answers the cycle after the request stage
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prog_rdata <= 16'h0000;
      primary_rdata <= 32'h00000000;
      secondary_read_data_bus <= 16'h0000;
    end else begin
      if (prog_rd_q) begin
        prog_rdata <= pm_rdata;
      end
      if (pri_rd_q) begin
        primary_rdata <= pri_rdata_mux;
      end
      if (sec_rd_q) begin
        secondary_read_data_bus <= ram2_rdata;
      end
    end
  end

  // checks
  property p_byte_msb;
    @(posedge ref_clk) disable iff (!nrst)
      (pri_act && pri_byte) |=>
        (!ram_addr[23] && !dflash.addr[23] && !peripheral_register_bus.addr[23]);
  endproperty
  a_byte_msb: assert property (p_byte_msb) else $error("byte msb not cleared");

  property p_prog_low;
    @(posedge ref_clk) disable iff (!nrst)
      prog_wr |=> (pm_wr && pm_wdata == $past(core_wdata[15:0]));
  endproperty
  a_prog_low: assert property (p_prog_low) else $error("prog write data wrong");

  property p_one_target;
    @(posedge ref_clk) disable iff (!nrst)
      $onehot0({ram_rd | ram_wr, dflash.rd | dflash.wr,
                peripheral_register_bus.rd | peripheral_register_bus.wr});
  endproperty
  a_one_target: assert property (p_one_target) else $error("multiple targets");

  property p_prog_fetch;
    @(posedge ref_clk) disable iff (!nrst)
      prog_rd |=> pm_rd && pm_addr == $past(prog_addr) ##1 prog_rdata == $past(pm_rdata);
  endproperty
  a_prog_fetch: assert property (p_prog_fetch) else $error("fetch path wrong");

  property p_sec_read;
    @(posedge ref_clk) disable iff (!nrst)
      sec_rd |=> ram2_rd ##1 secondary_read_data_bus == $past(ram2_rdata);
  endproperty
  a_sec_read: assert property (p_sec_read) else $error("secondary read wrong");

  property p_periph_nowait;
    @(posedge ref_clk) disable iff (!nrst)
      peripheral_register_bus.rd |=> primary_rdata == {16'h0000, $past(periph_rdata)};
  endproperty
  a_periph_nowait: assert property (p_periph_nowait) else $error("peripheral read late");

  property p_periph_wdata;
    @(posedge ref_clk) disable iff (!nrst)
      (pri_req.wr && tgt == fabric_pkg::TGT_PERIPH) |=>
        peripheral_register_bus.wr && peripheral_register_bus.wdata == $past(pri_req.wdata[15:0]);
  endproperty
  a_periph_wdata: assert property (p_periph_wdata) else $error("peripheral write wrong");

  // flash data writes go straight to the array with the low half of the write bus
  property p_dflash_wdata;
    @(posedge ref_clk) disable iff (!nrst)
      (pri_req.wr && tgt == fabric_pkg::TGT_DFLASH) |=>
        (dflash.wr && dflash.wdata == $past(pri_req.wdata[15:0]));
  endproperty
  a_dflash_wdata: assert property (p_dflash_wdata) else $error("flash write data wrong");

  // an access that hits no region raises the flag and strobes no target
  property p_unmapped;
    @(posedge ref_clk) disable iff (!nrst)
      (pri_act && tgt == fabric_pkg::TGT_NONE) |=>
        (pri_unmapped && !ram_rd && !ram_wr && !dflash.rd && !dflash.wr &&
         !peripheral_register_bus.rd && !peripheral_register_bus.wr);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access routed");

  property p_ram_wide;
    @(posedge ref_clk) disable iff (!nrst)
      ram_rd |=> primary_rdata == $past(ram_rdata);
  endproperty
  a_ram_wide: assert property (p_ram_wide) else $error("ram 32-bit read wrong");

  property p_three;
    @(posedge ref_clk) disable iff (!nrst)
      (prog_rd && sec_rd && pri_req.rd && tgt == fabric_pkg::TGT_RAM) |=>
        (pm_rd && ram2_rd && ram_rd);
  endproperty
  a_three: assert property (p_three) else $error("parallel access dropped");
endmodule // core_system_bus_fabric

/* tb/fabric_mem_model.sv */
`timescale 1ns/100ps
// memories and peripherals answering in the cycle their strobe is high
module fabric_mem_model (
  input wire logic pm_rd,
  input wire logic [fabric_pkg::PAB_W-1:0] pm_addr,
  output logic [fabric_pkg::WORD_W-1:0] pm_rdata,
  input wire logic ram_rd,
  input wire logic [fabric_pkg::XAB_W-1:0] ram_addr,
  output logic [fabric_pkg::LONG_W-1:0] ram_rdata,
  input wire logic ram2_rd,
  input wire logic [fabric_pkg::XAB_W-1:0] ram2_addr,
  output logic [fabric_pkg::WORD_W-1:0] ram2_rdata,
  input wire fabric_pkg::port16_s dflash,
  output logic [fabric_pkg::WORD_W-1:0] dflash_rdata,
  input wire fabric_pkg::port16_s peripheral_register_bus,
  output logic [fabric_pkg::WORD_W-1:0] periph_rdata
);
  // selected ports return a known word, idle ports the inverse
  assign pm_rdata = (pm_addr[15:0] ^ 16'h5A5A) ^ {16{~pm_rd}};
  assign ram_rdata = {ram_addr[15:0], ~ram_addr[15:0]} ^ {32{~ram_rd}};
  assign ram2_rdata = (ram2_addr[15:0] ^ 16'h3C3C) ^ {16{~ram2_rd}};
  assign dflash_rdata = dflash.rd ? 16'hB00F : 16'h4FF0;
  assign periph_rdata = peripheral_register_bus.rd ? 16'hF00F : 16'h0FF0;
endmodule // fabric_mem_model

/* tb/core_system_bus_fabric_tb.sv */
`timescale 1ns/100ps
// directed bench for the system bus fabric
module core_system_bus_fabric_tb;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic prog_rd = 1'h0;
  logic prog_wr = 1'h0;
  logic sec_rd = 1'h0;
  logic [20:0] prog_addr = 21'h0;
  logic [31:0] core_wdata = 32'h0;
  logic [23:0] secondary_data_address_bus = 24'h0;
  fabric_pkg::pri_req_s pri_req = '0;
  logic [15:0] prog_rdata, pm_wdata, pm_rdata, ram2_rdata, secondary_read_data_bus;
  logic [15:0] dflash_rdata, periph_rdata;
  logic [31:0] primary_rdata, ram_wdata, ram_rdata;
  logic pri_unmapped, pm_rd, pm_wr, ram_rd, ram_wr, ram2_rd, seen;
  logic [20:0] pm_addr;
  logic [23:0] ram_addr, ram2_addr;
  fabric_pkg::size_e ram_size;
  fabric_pkg::port16_s dflash, peripheral_register_bus;
  int bad_count = 0;
  int total_checks = 0;

  always #5 ref_clk = ~ref_clk;

  core_system_bus_fabric DUT (.ref_clk, .nrst, .prog_rd, .prog_wr, .prog_addr, .core_wdata,
    .prog_rdata, .pri_req, .primary_rdata, .pri_unmapped, .sec_rd, .secondary_data_address_bus,
    .secondary_read_data_bus, .pm_rd, .pm_wr, .pm_addr, .pm_wdata, .pm_rdata, .ram_rd, .ram_wr,
    .ram_size, .ram_addr, .ram_wdata, .ram_rdata, .ram2_rd, .ram2_addr, .ram2_rdata, .dflash,
    .dflash_rdata, .peripheral_register_bus, .periph_rdata);
  fabric_mem_model mem (.pm_rd, .pm_addr, .pm_rdata, .ram_rd, .ram_addr, .ram_rdata, .ram2_rd,
    .ram2_addr, .ram2_rdata, .dflash, .dflash_rdata, .peripheral_register_bus, .periph_rdata);

  // step to just after the next rising edge
  task automatic cyc();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // program read then write, back to back
  task automatic t_prog();
    prog_rd = 1'h1;
    prog_addr = 21'h1ABCDE;
    cyc();
    prog_rd = 1'h0;
    prog_wr = 1'h1;
    core_wdata = 32'h1234CAFE;
    chk({pm_rd, pm_addr}, {1'h1, 21'h1ABCDE});
    cyc();
    prog_wr = 1'h0;
    chk(prog_rdata, 16'hE684);
    chk({pm_rd, pm_wr, pm_wdata}, {2'h1, 16'hCAFE});
  endtask

  // long write at the RAM top, long read, byte read with top bit set
  task automatic t_ram();
    pri_req = '{1'h0, 1'h1, fabric_pkg::SZ_LONG, 24'h001FFF, 32'h89ABCDEF};
    cyc();
    pri_req = '{1'h1, 1'h0, fabric_pkg::SZ_LONG, 24'h000100, 32'h0};
    chk({ram_wr, ram_addr}, {1'h1, 24'h001FFF});
    chk(ram_wdata, 32'h89ABCDEF);
    chk(ram_size, fabric_pkg::SZ_LONG);
    cyc();
    pri_req = '{1'h1, 1'h0, fabric_pkg::SZ_BYTE, 24'h800010, 32'h0};
    chk({ram_rd, ram_wr}, 2'h2);
    cyc();
    pri_req = '0;
    chk(primary_rdata, 32'h0100FEFF);
    chk({ram_rd, ram_addr}, {1'h1, 24'h000010});
    chk(ram_size, fabric_pkg::SZ_BYTE);
  endtask

  // peripheral write and read, then a data flash read and write
  task automatic t_periph();
    pri_req = '{1'h0, 1'h1, fabric_pkg::SZ_WORD, 24'h00F004, 32'hFFFF1357};
    cyc();
    pri_req = '{1'h1, 1'h0, fabric_pkg::SZ_WORD, 24'h00FFFF, 32'h0};
    chk({peripheral_register_bus.wr, peripheral_register_bus.wdata}, 17'h11357);
    chk(peripheral_register_bus.addr, 24'h00F004);
    chk(ram_wr, 1'h0);
    cyc();
    pri_req = '{1'h1, 1'h0, fabric_pkg::SZ_WORD, 24'h004000, 32'h0};
    chk(peripheral_register_bus.rd, 1'h1);
    cyc();
    pri_req = '{1'h0, 1'h1, fabric_pkg::SZ_WORD, 24'h004FFF, 32'hAAAA2468};
    chk(primary_rdata, 32'h0000F00F);
    chk(dflash.rd, 1'h1);
    cyc();
    chk(primary_rdata, 32'h0000B00F);
    chk({dflash.wr, dflash.addr}, {1'h1, 24'h004FFF});
    chk(dflash.wdata, 16'h2468);
    chk(ram_wr, 1'h0);
  endtask

  // access in the hole between RAM and data flash
  task automatic t_unmapped();
    pri_req = '{1'h1, 1'h0, fabric_pkg::SZ_WORD, 24'h002000, 32'h0};
    cyc();
    pri_req = '0;
    seen = pri_unmapped;
    chk({ram_rd, dflash.rd, peripheral_register_bus.rd}, 3'h0);
    cyc();
    chk({seen, pri_unmapped}, 2'h2);
    chk(primary_rdata, 32'h0);
  endtask

  // program, primary and secondary in one cycle
  task automatic t_three();
    prog_rd = 1'h1;
    prog_addr = 21'h000042;
    sec_rd = 1'h1;
    secondary_data_address_bus = 24'h000222;
    pri_req = '{1'h1, 1'h0, fabric_pkg::SZ_LONG, 24'h000300, 32'h0};
    cyc();
    prog_rd = 1'h0;
    sec_rd = 1'h0;
    pri_req = '0;
    chk({pm_rd, ram_rd, ram2_rd}, 3'h7);
    chk(ram2_addr, 24'h000222);
    cyc();
    chk(prog_rdata, 16'h5A18);
    chk(primary_rdata, 32'h0300FCFF);
    chk(secondary_read_data_bus, 16'h3E1E);
  endtask

  initial begin
    repeat (4) cyc();
    chk({pm_rd, ram_rd, ram2_rd, pri_unmapped}, 4'h0);
    nrst = 1'h1;
    t_prog();
    t_ram();
    t_periph();
    t_unmapped();
    t_three();
    print_verdict();
  end
endmodule // core_system_bus_fabric_tb
